/* bench/dme_engine_tb.sv */
// Purpose: self-checking bench of the DSP engine datapath
// Assumes: register reads give accumulator and flag state
// Notes: integer model updated at each operation
`timescale 1ns/1ps
module dme_engine_tb import dme_pkg::*; ;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic op_valid, op_acc_sel, op_byte, awready, wready, bvalid, arready;
	logic rvalid, wb_valid, imul_valid, arith_trap_req;
	logic [7:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata, imul_result;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp_q;
	logic [15:0] wb_addr, wb_data, op_x, op_y, r13;
	logic [4:0] op_shift;
	dme_op_t op_code;
	dme_wb_t op_wb_mode;
	int mismatches, n_compared;
	logic [39:0] am [2];
	bit gm [2];
	bit sm [2];
	logic [9:0] ctl;
	logic [15:0] em [logic [15:0]];
	logic [15:0] lw;

	dme_engine dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.op_valid(op_valid), .op_code(op_code), .op_acc_sel(op_acc_sel),
		.op_x(op_x), .op_y(op_y), .op_shift(op_shift), .op_byte(op_byte),
		.op_wb_mode(op_wb_mode), .wb_valid(wb_valid), .wb_addr(wb_addr),
		.wb_data(wb_data), .imul_valid(imul_valid),
		.imul_result(imul_result), .arith_trap_req(arith_trap_req));
	dme_mem_model mem_u (.aclk(aclk), .wb_valid(wb_valid),
		.wb_addr(wb_addr), .wb_data(wb_data));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		bit ta;
		bit tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awready && !ta) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !tw) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp_q = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		dt = rdata;
		resp_q = rresp;
		rready <= 1'b0;
	endtask

	function automatic logic [39:0] mprod(logic [15:0] x, logic [15:0] y,
		bit im);
		longint a;
		longint b;
		longint p;
		a = ctl[CB_UNSIGNED] ? longint'(x) : longint'($signed(x));
		b = ctl[CB_UNSIGNED] ? longint'(y) : longint'($signed(y));
		p = a * b;
		if (!im) begin
			p = p <<< 1;
		end
		return {{7{p[32]}}, p[32:0]};
	endfunction

	function automatic logic [39:0] shf(logic [39:0] v, logic [4:0] s);
		if (s[4]) begin
			return v << 5'(-s);
		end
		return $signed(v) >>> s;
	endfunction

	function automatic logic [15:0] rnd(logic [39:0] a);
		logic [24:0] f;
		f = {a[39], a[39:16]} + 25'(a[15]);
		if (!ctl[CB_RND_CONV] && a[15:0] == RND_HALF) begin
			f = {a[39], a[39:16]} + 25'(a[16]);
		end
		if (ctl[CB_SAT_DW] && !a[39] && $signed(f) > 32767) begin
			return WORD_MAX;
		end
		if (ctl[CB_SAT_DW] && a[39] && $signed(f) < -32768) begin
			return WORD_MIN;
		end
		return f[15:0];
	endfunction

	task automatic do_op(input dme_op_t c, input bit s, input logic [15:0] x,
		input logic [15:0] y, input logic [4:0] sh, input dme_wb_t wm);
		logic [39:0] b, p, sum, im;
		logic [15:0] w, d, a;
		bit sub, wop, v, en;
		w = rnd(am[!s]);
		d = x - y;
		b = am[s];
		p = 40'h0;
		sub = 1'b0;
		case (c)
		multiply_op, square_op, neg_multiply_op, diff_square_op, load_acc_op,
		op_clear, acc_negate_op: begin
			b = 40'h0;
		end
		default: ;
		endcase
		case (c)
		multiply_op, mult_accumulate_op, neg_multiply_op, mult_subtract_op: begin
			p = mprod(x, y, ctl[CB_INT]);
		end
		square_op, square_acc_op: p = mprod(x, x, ctl[CB_INT]);
		diff_square_op, diff_square_acc_op: p = mprod(d, d, ctl[CB_INT]);
		acc_add_op: p = shf(am[!s], sh);
		acc_sub_op: p = am[!s];
		acc_negate_op: p = am[s];
		load_acc_op: p = shf({{8{x[15]}}, x, 16'h0000}, sh);
		default: ;
		endcase
		sub = c inside {neg_multiply_op, mult_subtract_op, acc_sub_op,
			acc_negate_op};
		// Adder with true or complemented side
		sum = sub ? b - p : b + p;
		v = (b[39] == (p[39] ^ sub)) && (sum[39] != b[39]);
		en = ctl[CB_SAT_A + int'(s)];
		if (!(c inside {prefetch_store_op, int_multiply_op})) begin
			am[s] = sum;
			gm[s] = !(&sum[39:32] || !(|sum[39:32]));
			if (en && !ctl[CB_SAT_WIDE]) begin
				gm[s] = 1'b0;
				if (v || !(&sum[39:31] || !(|sum[39:31]))) begin
					am[s] = (sum[39] ^ v) ? SAT1_NEG : SAT1_POS;
					sm[s] = 1'b1;
				end
			end else if (v) begin
				sm[s] = 1'b1;
				if (en) begin
					am[s] = sum[39] ? SAT9_POS : SAT9_NEG;
					gm[s] = 1'b1;
				end
			end
		end
		im = mprod(x, y, 1'b1);
		if (sh[0]) begin
			im = {24'h0, 8'h0, x[7:0]};
			im = im * y[7:0];
		end
		wop = c inside {op_clear, mult_accumulate_op, mult_subtract_op,
			prefetch_store_op};
		a = r13;
		if (wop && wm != wb_none) begin
			lw = w;
		end
		// Write-back into register 13 or memory
		if (wop && wm == wb_direct) begin
			r13 = w;
		end
		if (wop && wm == wb_postinc) begin
			r13 = r13 + WB_STEP;
			em[a] = w;
		end
		@(posedge aclk);
		op_valid <= 1'b1;
		op_code <= c;
		op_acc_sel <= s;
		op_x <= x;
		op_y <= y;
		op_shift <= sh;
		op_byte <= sh[0];
		op_wb_mode <= wm;
		@(posedge aclk);
		op_valid <= 1'b0;
		@(posedge aclk);
		chk(wb_valid, wop && wm == wb_postinc);
		if (wop && wm == wb_postinc) begin
			chk({wb_addr, wb_data}, {a, w});
		end
		chk(imul_valid, c == int_multiply_op);
		if (c == int_multiply_op) begin
			chk(imul_result, im[31:0]);
		end
		chk(arith_trap_req, (gm[0] & ctl[CB_TRAP_A]) | (gm[1] & ctl[CB_TRAP_B])
			| (ctl[CB_TRAP_CAT] & ((sm[0] & !ctl[CB_SAT_A])
			| (sm[1] & !ctl[CB_SAT_B]))));
	endtask

	task automatic chk_state();
		logic [31:0] lo, hi;
		rd(REG_ACCUMULATOR_A_LO, lo);
		rd(REG_ACCUMULATOR_A_HI, hi);
		chk({hi[7:0], lo}, am[0]);
		rd(REG_ACCUMULATOR_B_LO, lo);
		rd(REG_ACCUMULATOR_B_HI, hi);
		chk({hi[7:0], lo}, am[1]);
		rd(REG_STAT, lo);
		chk(lo, {sm[0] | sm[1], gm[0] | gm[1], sm[1], sm[0], gm[1], gm[0]});
		rd(REG_WREG13, lo);
		chk(lo, r13);
		rd(REG_WB_WORD, lo);
		chk(lo, lw);
	endtask

	dme_op_t ops [15] = '{op_clear, multiply_op, neg_multiply_op, square_op,
		mult_accumulate_op, mult_subtract_op, square_acc_op, diff_square_op,
		diff_square_acc_op, acc_add_op, acc_sub_op, acc_negate_op, load_acc_op,
		int_multiply_op, prefetch_store_op};
	logic [9:0] cfg [5] = '{10'h000, 10'h386, 10'h03B, 10'h05C, 10'h208};

	initial begin
		logic [31:0] rv;
		{awvalid, wvalid, bready, arvalid, rready, op_valid} = 6'h00;
		{awaddr, araddr, awprot, arprot, wdata, wstrb} = 58'h000000000F;
		{op_acc_sel, op_byte, op_x, op_y, op_shift} = 39'h0;
		op_code = op_none;
		op_wb_mode = wb_none;
		aresetn = 1'b0;
		mismatches = 0;
		n_compared = 0;
		am = '{40'h0, 40'h0};
		ctl = CTRL_RST;
		r13 = 16'h0000;
		lw = 16'h0000;
		rv = $urandom(32'h2f134f29);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		chk_state();
		rd(REG_CTRL, rv);
		chk(rv, 40'h0);
		rd(8'h20, rv);
		chk({rv, resp_q}, {32'h0, RESP_ERR});
		wr(8'h24, 32'hFFFFFFFF);
		chk(resp_q, RESP_ERR);
		foreach (cfg[i]) begin
			ctl = cfg[i];
			wr(REG_CTRL, {22'h0, ctl});
			wr(REG_STAT, 32'h0000002C);
			sm = '{1'b0, 1'b0};
			r13 = 16'(2 * $urandom_range(0, 4000));
			wr(REG_WREG13, {16'h0, r13});
			repeat (40) begin
				do_op(ops[$urandom_range(0, 14)], 1'($urandom), 16'($urandom),
					16'($urandom), 5'($urandom_range(0, 16) - 8),
					dme_wb_t'($urandom_range(0, 2)));
				chk_state();
			end
			repeat (300) begin
				do_op(mult_accumulate_op, 1'b0, 16'h8000,
					i[0] ? 16'h8000 : 16'h7FFF, 5'h0, wb_none);
			end
			chk_state();
			// Software clear of one sticky flag
			wr(REG_STAT, 32'h00000004);
			sm[0] = 1'b0;
			chk_state();
		end
		foreach (em[k]) begin
			chk(mem_u.mem[k], em[k]);
		end
		complete_run();
	end

	initial begin
		repeat (60000) @(posedge aclk);
		mismatches++;
		complete_run();
	end
endmodule // dme_engine_tb

/* bench/dme_mem_model.sv */
// Purpose: data space memory behind the write-back port
// Assumes: one word stored per wb_valid cycle
// Notes: byte addresses, word aligned
`timescale 1ns/1ps
module dme_mem_model (
	// Clock
	input wire logic aclk,
	// Write-back port
	input wire logic wb_valid,
	input wire logic [15:0] wb_addr,
	input wire logic [15:0] wb_data
);
	logic [15:0] mem [logic [15:0]];
	always @(posedge aclk) begin
		if (wb_valid === 1'b1) begin
			mem[wb_addr] = wb_data;
		end
	end
endmodule // dme_mem_model

/* src/dme_engine.sv */
// Purpose: DSP engine datapath with two 40-bit accumulators
// Assumes: one operation per cycle from the decoder, AXI4-Lite registers
// Notes: Notes on behaviour listed below
// Notes on behaviour
// - Accumulator add, subtract and negate need no memory operand.
// - Multiplier operands widened to 17 bits, zero or sign filled.
// - 33-bit product sign-extended to 40 bits before the adder.
// - Scaler gives 1.31 fractional or 32-bit integer product.
// - Fractional 16x16 multiply yields a 1.31 product.
// - Integer multiply: byte gives 16 bits, word gives 32 bits.
// - Selected accumulator is adder source and destination.
// - Add and load operands pass the barrel shifter first.
// - Adder side forcible to zero; true or complemented other side.
// - Guard flag set when bits 32..39 differ after adder use.
// - Guard flags follow only the latest operation on that accumulator.
// - Guard flag with its trap enable requests an arithmetic trap.
// - Saturation flags set by hardware, cleared only by software.
// - Saturation off: flag records bit 39 overflow, optional trap.
// - Status shows OR of guard flags and OR of saturation flags.
// - Saturation decided from sum, overflows, enables and width.
// - Wide mode: bit 39 overflow loads 9.31 limit, sets flag.
// - Normal mode: bit 31 overflow loads 1.31 limit, sets flag.
// - Normal saturation active: guard flags never set.
// - Catastrophic mode wraps, sets sticky flag, traps if enabled.
// - Clear, multiply-accumulate, multiply-subtract and prefetch-store ops may write back other accumulator rounded high.
// - Direct write-back puts rounded word into working register 13.
// - Indirect write-back stores at register 13, then adds 2.
// - Conventional adds bit 15; convergent ties use bit 16.
// - Data write saturation clamps to 0x7FFF or 0x8000.
`timescale 1ns/1ps
module dme_engine import dme_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Operation from decoder
	input wire logic op_valid,
	input wire dme_op_t op_code,
	input wire logic op_acc_sel,
	input wire logic [15:0] op_x,
	input wire logic [15:0] op_y,
	input wire logic [4:0] op_shift,
	input wire logic op_byte,
	input wire dme_wb_t op_wb_mode,
	// Results
	output logic wb_valid,
	output logic [15:0] wb_addr,
	output logic [15:0] wb_data,
	output logic imul_valid,
	output logic [31:0] imul_result,
	output logic arith_trap_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [9:0] ctrl_ff;
	logic [39:0] acc_ff [2];
	logic [1:0] guard_ff;
	logic [1:0] sat_ff;
	logic [15:0] wreg13_ff;
	logic [15:0] wb_word_ff;
	logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic wb_valid_ff, imul_valid_ff;
	logic [15:0] wb_addr_ff, wb_data_ff;
	logic [31:0] imul_ff;

	logic fire, uses_adder, zero_a, sub_sel, diff_op, sq_op, wb_ok;
	logic [15:0] diff, mx, my, wb_word;
	logic [32:0] prod;
	logic [31:0] int_prod;
	logic [39:0] cur, other, prod40, shin, shout, opnd_a, opnd_b, beff, sum;
	logic [4:0] sh_amt;
	logic ovf39, ovf31, guard_bad, sat_on, sat_wide;
	logic [39:0] nxt_acc;
	logic nxt_guard, set_sat;
	logic wr_go;
	logic [31:0] wmask, wr_val, rd_val;
	logic [1:0] clr_sat;
	logic rd_hit, wr_hit;

	assign fire = op_valid && op_code != op_none;
	assign uses_adder = fire && op_code != int_multiply_op
		&& op_code != prefetch_store_op;
	assign diff_op = op_code == diff_square_op
		|| op_code == diff_square_acc_op;
	assign sq_op = op_code == square_op || op_code == square_acc_op;
	assign diff = op_x - op_y;
	assign mx = diff_op ? diff : op_x;
	assign my = (diff_op || sq_op) ? mx : op_y;

	dme_mult u_mult (
		.mx(mx),
		.my(my),
		.is_unsigned(ctrl_ff[CB_UNSIGNED]),
		.int_mode(ctrl_ff[CB_INT] || op_code == int_multiply_op),
		.byte_mode(op_byte),
		.prod(prod),
		.int_prod(int_prod)
	);

	assign cur = acc_ff[op_acc_sel];
	assign other = acc_ff[!op_acc_sel];
	assign prod40 = {{7{prod[32]}}, prod};

	// barrel shifter on add and load data
	assign shin = op_code == load_acc_op ?
		{{8{op_x[15]}}, op_x, 16'h0000} : other;
	assign sh_amt = op_shift[4] ? 5'(-op_shift) : op_shift;
	assign shout = op_shift[4] ? shin << sh_amt :
		40'($signed(shin) >>> sh_amt);

	always_comb begin
		zero_a = 1'b0;
		sub_sel = 1'b0;
		opnd_b = prod40;
		unique case (op_code)
			op_clear: begin
				zero_a = 1'b1;
				opnd_b = '0;
			end
			multiply_op, square_op, diff_square_op: zero_a = 1'b1;
			neg_multiply_op: begin
				zero_a = 1'b1;
				sub_sel = 1'b1;
			end
			mult_subtract_op: sub_sel = 1'b1;
			acc_add_op: opnd_b = shout;
			acc_sub_op: begin
				opnd_b = other;
				sub_sel = 1'b1;
			end
			acc_negate_op: begin
				zero_a = 1'b1;
				opnd_b = cur;
				sub_sel = 1'b1;
			end
			load_acc_op: begin
				zero_a = 1'b1;
				opnd_b = shout;
			end
			default: opnd_b = prod40;
		endcase
	end

	// zero side and true or complement side
	assign opnd_a = zero_a ? '0 : cur;
	assign beff = sub_sel ? ~opnd_b : opnd_b;
	assign sum = opnd_a + beff + {39'h0, sub_sel};
	assign ovf39 = opnd_a[39] == beff[39] && sum[39] != opnd_a[39];
	assign ovf31 = sum[39:31] != {9{sum[31]}};
	// guard bits 32..39 not all equal
	assign guard_bad = sum[39:32] != {8{sum[39]}};

	assign sat_on = op_acc_sel ? ctrl_ff[CB_SAT_B] : ctrl_ff[CB_SAT_A];
	assign sat_wide = ctrl_ff[CB_SAT_WIDE];

	always_comb begin
		nxt_acc = sum;
		set_sat = 1'b0;
		nxt_guard = guard_bad;
		if (sat_on && sat_wide) begin
			if (ovf39) begin
				nxt_acc = sum[39] ? SAT9_POS : SAT9_NEG;
				set_sat = 1'b1;
				nxt_guard = 1'b1;
			end
		end else if (sat_on) begin
			nxt_guard = 1'b0;
			if (ovf39 || ovf31) begin
				nxt_acc = (ovf39 ? !sum[39] : sum[39]) ? SAT1_NEG : SAT1_POS;
				set_sat = 1'b1;
			end
		end else begin
			// wrap and record bit 39 overflow
			set_sat = ovf39;
		end
	end

	assign wb_ok = fire && op_wb_mode != wb_none && (op_code == op_clear
		|| op_code == mult_accumulate_op || op_code == mult_subtract_op
		|| op_code == prefetch_store_op);

	dme_round u_round (
		.acc(other),
		.rnd_conv(ctrl_ff[CB_RND_CONV]),
		.sat_en(ctrl_ff[CB_SAT_DW]),
		.word(wb_word)
	);

	// Bus write decode
	assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
		{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
	assign wr_val = w_data_ff & wmask;
	assign wr_hit = aw_addr_ff == REG_CTRL || aw_addr_ff == REG_STAT
		|| aw_addr_ff == REG_WREG13;
	assign clr_sat[0] = wr_go && aw_addr_ff == REG_STAT
		&& (wr_val[SB_SAT_A] || wr_val[SB_SAT_ANY]);
	assign clr_sat[1] = wr_go && aw_addr_ff == REG_STAT
		&& (wr_val[SB_SAT_B] || wr_val[SB_SAT_ANY]);

	// accumulators and flags, one clock edge per operation
	for (genvar i = 0; i < 2; i++) begin : g_acc
		logic hit;
		assign hit = uses_adder && op_acc_sel == 1'(i);
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				acc_ff[i] <= '0;
				guard_ff[i] <= 1'b0;
			end else if (hit) begin
				acc_ff[i] <= nxt_acc;
				guard_ff[i] <= nxt_guard;
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sat_ff[i] <= 1'b0;
			end else if (hit && set_sat) begin
				sat_ff[i] <= 1'b1;
			end else if (clr_sat[i]) begin
				sat_ff[i] <= 1'b0;
			end
		end
	end

	assign arith_trap_req = (guard_ff[0] && ctrl_ff[CB_TRAP_A])
		|| (guard_ff[1] && ctrl_ff[CB_TRAP_B])
		|| (ctrl_ff[CB_TRAP_CAT] && ((sat_ff[0] && !ctrl_ff[CB_SAT_A])
		|| (sat_ff[1] && !ctrl_ff[CB_SAT_B])));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_go && aw_addr_ff == REG_CTRL) begin
			ctrl_ff <= (ctrl_ff & ~wmask[9:0]) | wr_val[9:0];
		end
	end

	// write-back to register 13 or memory
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wreg13_ff <= '0;
			wb_word_ff <= '0;
			wb_valid_ff <= 1'b0;
			wb_addr_ff <= '0;
			wb_data_ff <= '0;
		end else begin
			wb_valid_ff <= wb_ok && op_wb_mode == wb_postinc;
			if (wb_ok) begin
				wb_word_ff <= wb_word;
			end
			if (wb_ok && op_wb_mode == wb_direct) begin
				wreg13_ff <= wb_word;
			end else if (wb_ok && op_wb_mode == wb_postinc) begin
				wb_addr_ff <= wreg13_ff;
				wb_data_ff <= wb_word;
				wreg13_ff <= wreg13_ff + WB_STEP;
			end else if (wr_go && aw_addr_ff == REG_WREG13) begin
				wreg13_ff <= (wreg13_ff & ~wmask[15:0]) | wr_val[15:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			imul_valid_ff <= 1'b0;
			imul_ff <= '0;
		end else begin
			imul_valid_ff <= fire && op_code == int_multiply_op;
			if (fire && op_code == int_multiply_op) begin
				imul_ff <= int_prod;
			end
		end
	end

	// Write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OK;
			aw_addr_ff <= '0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= wdata;
				w_strb_ff <= wstrb;
			end
			if (wr_go) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? RESP_OK : RESP_ERR;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_val = '0;
		unique case (araddr)
			REG_CTRL: rd_val = {22'h0, ctrl_ff};
			REG_STAT: rd_val = {26'h0, |sat_ff, |guard_ff, sat_ff, guard_ff};
			REG_ACCUMULATOR_A_LO: rd_val = acc_ff[0][31:0];
			REG_ACCUMULATOR_A_HI: rd_val = {24'h0, acc_ff[0][39:32]};
			REG_ACCUMULATOR_B_LO: rd_val = acc_ff[1][31:0];
			REG_ACCUMULATOR_B_HI: rd_val = {24'h0, acc_ff[1][39:32]};
			REG_WREG13: rd_val = {16'h0, wreg13_ff};
			REG_WB_WORD: rd_val = {16'h0, wb_word_ff};
			default: rd_hit = 1'b0;
		endcase
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OK;
		end else if (arvalid && arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_val;
			rresp_ff <= rd_hit ? RESP_OK : RESP_ERR;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign awready = !aw_hold_ff && !bvalid_ff;
	assign wready = !w_hold_ff && !bvalid_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = !rvalid_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign wb_valid = wb_valid_ff;
	assign wb_addr = wb_addr_ff;
	assign wb_data = wb_data_ff;
	assign imul_valid = imul_valid_ff;
	assign imul_result = imul_ff;

	logic fire_a;
	assign fire_a = uses_adder && !op_acc_sel;

	guard_calc_a: assert property (fire_a && !ctrl_ff[CB_SAT_A]
		|=> guard_ff[0] == ($past(sum[39:32]) != {8{$past(sum[39])}}))
		else $error("guard flag A wrong after adder");
	guard_norm_a: assert property (fire_a && ctrl_ff[CB_SAT_A]
		&& !ctrl_ff[CB_SAT_WIDE] |=> !guard_ff[0])
		else $error("guard set in normal mode");
	sat_hold_a: assert property (sat_ff[0] && !clr_sat[0]
		|=> sat_ff[0]) else $error("sticky flag A dropped");
	super_sat_a: assert property (fire_a && ctrl_ff[CB_SAT_A]
		&& ctrl_ff[CB_SAT_WIDE] && ovf39 |=> sat_ff[0]
		&& (acc_ff[0] == SAT9_POS || acc_ff[0] == SAT9_NEG))
		else $error("wide saturation value wrong");
	norm_sat_a: assert property (fire_a && ctrl_ff[CB_SAT_A]
		&& !ctrl_ff[CB_SAT_WIDE] && ovf31 |=> sat_ff[0]
		&& (acc_ff[0] == SAT1_POS || acc_ff[0] == SAT1_NEG))
		else $error("normal saturation value wrong");
	wrap_cat_a: assert property (fire_a && !ctrl_ff[CB_SAT_A]
		|=> acc_ff[0] == $past(sum)) else $error("catastrophic mode saturated");
	trap_req_a: assert property (guard_ff[0] && ctrl_ff[CB_TRAP_A]
		|-> arith_trap_req) else $error("missing trap request");
	post_inc_a: assert property (wb_ok && op_wb_mode == wb_postinc
		|=> wb_valid && wreg13_ff == $past(wreg13_ff) + WB_STEP)
		else $error("post increment write-back wrong");
	clear_op_a: assert property (fire_a && op_code == op_clear
		|=> acc_ff[0] == '0) else $error("clear did not zero accumulator");
	either_stat_a: assert property (arvalid && arready
		&& araddr == REG_STAT |=> rdata[SB_SAT_ANY] == |$past(sat_ff))
		else $error("combined saturation bit wrong");

	super_sat_c: cover property (fire && sat_wide && sat_on && ovf39);
	post_inc_c: cover property (wb_valid);
	sat_clear_c: cover property (sat_ff[0] ##1 !sat_ff[0]);
	trap_req_c: cover property (arith_trap_req);
endmodule // dme_engine

/* src/dme_mult.sv */
// Purpose: 17x17 multiplier with fractional or integer scaler
// Assumes: combinational, result used in the same cycle
// Notes: byte products are unsigned 8x8
`timescale 1ns/1ps
module dme_mult import dme_pkg::*; (
	// Operands
	input wire logic [15:0] mx,
	input wire logic [15:0] my,
	// Modes
	input wire logic is_unsigned,
	input wire logic int_mode,
	input wire logic byte_mode,
	// Results
	output logic [32:0] prod,
	output logic [31:0] int_prod
);
	logic signed [16:0] ex;
	logic signed [16:0] ey;
	logic signed [33:0] raw;
	logic [15:0] bprod;
	assign ex = {is_unsigned ? 1'b0 : mx[15], mx};
	assign ey = {is_unsigned ? 1'b0 : my[15], my};
	assign raw = ex * ey;
	assign prod = int_mode ? raw[32:0] : {raw[31:0], 1'b0};
	assign bprod = mx[7:0] * my[7:0];
	assign int_prod = byte_mode ? {16'h0000, bprod} : raw[31:0];
endmodule // dme_mult

/* src/dme_pkg.sv */
// Purpose: shared constants and types of the DSP engine datapath
// Assumes: 40-bit accumulators, 16-bit data words, AXI4-Lite registers
// Notes: offsets are byte addresses of 32-bit words
package dme_pkg;
	localparam int ACC_W = 40;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 8;
	localparam int CTRL_W = 10;
	localparam int STAT_W = 6;
	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_ACCUMULATOR_A_LO = 8'h08;
	localparam logic [7:0] REG_ACCUMULATOR_A_HI = 8'h0C;
	localparam logic [7:0] REG_ACCUMULATOR_B_LO = 8'h10;
	localparam logic [7:0] REG_ACCUMULATOR_B_HI = 8'h14;
	localparam logic [7:0] REG_WREG13 = 8'h18;
	localparam logic [7:0] REG_WB_WORD = 8'h1C;
	// Control fields
	localparam int CB_UNSIGNED = 0;
	localparam int CB_INT = 1;
	localparam int CB_RND_CONV = 2;
	localparam int CB_SAT_A = 3;
	localparam int CB_SAT_B = 4;
	localparam int CB_SAT_DW = 5;
	localparam int CB_SAT_WIDE = 6;
	localparam int CB_TRAP_A = 7;
	localparam int CB_TRAP_B = 8;
	localparam int CB_TRAP_CAT = 9;
	localparam logic [9:0] CTRL_RST = 10'h000;
	// Status fields
	localparam int SB_GUARD_A = 0;
	localparam int SB_GUARD_B = 1;
	localparam int SB_SAT_A = 2;
	localparam int SB_SAT_B = 3;
	localparam int SB_GUARD_ANY = 4;
	localparam int SB_SAT_ANY = 5;
	// Saturation values
	localparam logic [39:0] SAT9_POS = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] SAT9_NEG = 40'h80_0000_0000;
	localparam logic [39:0] SAT1_POS = 40'h00_7FFF_FFFF;
	localparam logic [39:0] SAT1_NEG = 40'hFF_8000_0000;
	localparam logic [15:0] RND_HALF = 16'h8000;
	localparam logic [15:0] WORD_MAX = 16'h7FFF;
	localparam logic [15:0] WORD_MIN = 16'h8000;
	localparam logic [15:0] WB_STEP = 16'h0002;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [3:0] {
		op_none, op_clear, multiply_op, neg_multiply_op,
		square_op, mult_accumulate_op, mult_subtract_op,
		square_acc_op, diff_square_op, diff_square_acc_op,
		acc_add_op, acc_sub_op, acc_negate_op, load_acc_op,
		int_multiply_op, prefetch_store_op
	} dme_op_t;
	typedef enum logic [1:0] {wb_none, wb_direct, wb_postinc} dme_wb_t;
endpackage

/* src/dme_round.sv */
// Purpose: round accumulator high word and saturate data writes
// Assumes: combinational
// Notes: sign taken from accumulator bit 39
`timescale 1ns/1ps
module dme_round import dme_pkg::*; (
	// Source
	input wire logic [39:0] acc,
	// Modes
	input wire logic rnd_conv,
	input wire logic sat_en,
	// Result
	output logic [15:0] word
);
	logic inc;
	logic [24:0] hi;
	logic pos_big;
	logic neg_big;
	assign inc = (acc[15:0] == RND_HALF && !rnd_conv) ? acc[16] : acc[15];
	assign hi = {acc[39], acc[39:16]} + {24'h000000, inc};
	// data write saturation, sign from bit 39
	assign pos_big = !acc[39] && hi[24:15] != 10'h000;
	assign neg_big = acc[39] && hi[24] && hi[23:15] != 9'h1FF;
	assign word = !sat_en ? hi[15:0] :
		pos_big ? WORD_MAX : neg_big ? WORD_MIN : hi[15:0];
endmodule // dme_round
